// ### verilog/osp_pkg.sv
// Shared constants for the octal serial host bus port and its host end
package osp_pkg;
   // Clock period and bus timing of the host end
   localparam int CLK_NS = 8;
   localparam int SETUP_NS = 24;
   localparam int STROBE_NS = 80;
   localparam int HOLD_NS = 40;
   // Least times round up to whole cycles
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 8;

   // Address fields
   localparam int ADDR_GLOBAL_BIT = 7;
   localparam int ADDR_CH_LSB = 4;
   localparam int ADDR_REG_LSB = 0;

   // Per-channel register offsets
   localparam logic [3:0] REG_IRQ_EN = 4'h1;
   localparam logic [3:0] REG_MODEM_CTL = 4'h4;
   localparam logic [3:0] REG_MODEM_STAT = 4'h6;
   localparam logic [3:0] REG_FEATURE = 4'h8;
   localparam logic [3:0] REG_ENH_FEATURE = 4'h9;
   // Global register holding the pending interrupt vector (read only)
   localparam logic [3:0] GREG_IRQ_PEND = 4'h0;

   // Field positions
   localparam int MC_READY_BIT = 0;
   localparam int MC_SEND_BIT = 1;
   localparam int MC_IR_BIT = 6;
   localparam int FC_THR_LSB = 0;
   localparam int FC_RX_INV_BIT = 4;
   localparam int FC_HALF_DUPLEX_BIT = 5;
   localparam int EF_AUTO_OUT_BIT = 6;
   localparam int EF_AUTO_IN_BIT = 7;
   localparam int IE_AUTO_OUT_BIT = 6;
   localparam int IE_AUTO_IN_BIT = 7;

   // Layout of the synchronised pin vector inside the device
   localparam int P_RX = 0;
   localparam int P_CTS = 8;
   localparam int P_DSR = 16;
   localparam int P_CD = 24;
   localparam int P_RI = 32;
   localparam int P_ADDR = 40;
   localparam int P_DATA = 48;
   localparam int P_RD = 56;
   localparam int P_WR = 57;
   localparam int P_CS = 58;
   localparam int P_STYLE = 59;
   localparam int PIN_W = 60;
   // All pins idle high after reset, so no edge is seen at release
   localparam logic [PIN_W-1:0] PIN_RST = {PIN_W{1'b1}};
   localparam logic [7:0] BUS_IDLE = 8'hff;
endpackage

// ### verilog/osp_bus_if.sv
// Parallel host bus between the host end and the serial port device
`timescale 1ns/1ps
interface osp_bus_if;
   logic [7:0] host_addr_bus;
   logic [7:0] host_data_out;
   logic host_data_oe;
   logic [7:0] dev_data_out;
   logic dev_data_oe;
   logic [7:0] host_byte_bus;
   logic read_strobe_n;
   logic write_strobe_n;
   logic chip_sel_n;
   logic bus_style;
   logic irq_out_n;
   logic irq_oe;
   logic irq_line_n;

   // Resolve the shared data bus; pull-up when nobody drives
   assign host_byte_bus = dev_data_oe ? dev_data_out :
                          host_data_oe ? host_data_out : osp_pkg::BUS_IDLE;
   // Open-drain interrupt with external pull-up
   assign irq_line_n = irq_oe ? irq_out_n : 1'b1;

   modport dev (
      input host_addr_bus, host_byte_bus, read_strobe_n, write_strobe_n,
      input chip_sel_n, bus_style,
      output dev_data_out, dev_data_oe, irq_out_n, irq_oe
   );
   modport host (
      output host_addr_bus, host_data_out, host_data_oe, read_strobe_n,
      output write_strobe_n, chip_sel_n, bus_style,
      input host_byte_bus, irq_line_n
   );
endinterface

// ### verilog/osp_device.sv
// Device end: host bus port, register file and per-channel pin logic
//
// Functional notes
// - Address bits 3:0 pick channel register
// - Address bits 6:4 pick channel zero to seven
// - Address bit 7 selects global registers
// - Style pin high separate strobes, low single
// - Read strobe fall drives addressed byte out
// - Write strobe fall starts, rise stores byte
// - Single style: host holds read strobe high
// - Single style: write strobe is direction level
// - Separate style: act only with chip select
// - Single style: chip select times each transfer
// - One shared open-drain active-low interrupt
// - Transmit pin carries normal or infrared data
// - Normal receive input idles high
// - Feature bit 4 inverts infrared receive pulses
// - Handshake outputs: general, auto, half-duplex
// - Auto output flow: enhanced and enable bit 6
// - Feature bits 3:0 set flow threshold
// - Auto input flow: enhanced and enable bit 7
// - Carrier and ring inputs readable as general
`timescale 1ns/1ps
module osp_device
   import osp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Host bus
   osp_bus_if.dev bus,
   // Serial engine side
   input wire logic [7:0] tx_data,
   input wire logic [7:0] tx_busy,
   input wire logic [7:0][3:0] rx_fill,
   input wire logic [7:0] chan_irq,
   output logic [7:0] rx_data,
   output logic [7:0] tx_allow,
   // Serial and modem pins
   output logic [7:0] serial_out_ch,
   input wire logic [7:0] serial_in_ch,
   output logic [7:0] request_send_n,
   input wire logic [7:0] clear_send_n,
   output logic [7:0] terminal_ready_n,
   input wire logic [7:0] set_ready_n,
   input wire logic [7:0] carrier_detect_n,
   input wire logic [7:0] ring_indicate_n
);
   import osp_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} osp_dev_state_e;

   typedef struct packed {
      osp_dev_state_e state;
      logic [PIN_W-1:0] pin1;
      logic [PIN_W-1:0] pin2;
      logic prev_rd;
      logic prev_wr;
      logic prev_cs;
      logic [7:0] addr;
      logic [7:0] wlatch;
      logic [7:0] dout;
      logic doe;
      logic [7:0][15:0][7:0] creg;
      logic [15:0][7:0] greg;
      logic [7:0] sout;
      logic [7:0] rts;
      logic [7:0] dtr;
      logic [7:0] rxd;
      logic [7:0] allow;
      logic irq_oe;
   } osp_dev_s;

   osp_dev_s r;
   osp_dev_s next_r;

   logic [PIN_W-1:0] pin_raw;
   logic rd_n;
   logic wr_n;
   logic cs_n;
   logic style;
   logic [7:0] addr_s;
   logic [7:0] data_s;
   logic [7:0][7:0] modem_stat;
   logic [7:0] pend;
   logic [7:0] rbyte;

   ////////////////////////////////////////////////////////////////////////
   // Every pin passes two flops; the strobes are edge-detected on stage two
   assign pin_raw = {bus.bus_style, bus.chip_sel_n, bus.write_strobe_n,
                     bus.read_strobe_n, bus.host_byte_bus,
                     bus.host_addr_bus, ring_indicate_n, carrier_detect_n,
                     set_ready_n, clear_send_n, serial_in_ch};
   assign rd_n = r.pin2[P_RD];
   assign wr_n = r.pin2[P_WR];
   assign cs_n = r.pin2[P_CS];
   assign style = r.pin2[P_STYLE];
   assign addr_s = r.pin2[P_ADDR +: 8];
   assign data_s = r.pin2[P_DATA +: 8];

   // Live modem status and pending interrupts per channel
   for (genvar g = 0; g < 8; g++) begin : g_chan
      assign modem_stat[g] = {~r.pin2[P_CD+g], ~r.pin2[P_RI+g],
                       ~r.pin2[P_DSR+g], ~r.pin2[P_CTS+g], 4'h0};
      assign pend[g] = chan_irq[g] & (r.creg[g][REG_IRQ_EN] != 8'h00);
   end

   // Byte returned for a read started at the current address
   always_comb begin
      rbyte = 8'h00;
      if (addr_s[ADDR_GLOBAL_BIT]) begin
         if (addr_s[ADDR_REG_LSB +: 4] == GREG_IRQ_PEND) begin
            rbyte = pend;
         end else begin
            rbyte = r.greg[addr_s[ADDR_REG_LSB +: 4]];
         end
      end else if (addr_s[ADDR_REG_LSB +: 4] == REG_MODEM_STAT) begin
         rbyte = modem_stat[addr_s[ADDR_CH_LSB +: 3]];
      end else begin
         rbyte = r.creg[addr_s[ADDR_CH_LSB +: 3]][addr_s[ADDR_REG_LSB +: 4]];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic: bus cycles, then per-channel pin functions
   always_comb begin
      logic [7:0] fc;
      logic [7:0] ef;
      logic [7:0] mc;
      logic [7:0] ie;
      logic full;
      logic rx_p;
      fc = 8'h00;
      ef = 8'h00;
      mc = 8'h00;
      ie = 8'h00;
      full = 1'b0;
      rx_p = 1'b1;
      next_r = r;
      next_r.pin1 = pin_raw;
      next_r.pin2 = r.pin1;
      next_r.prev_rd = rd_n;
      next_r.prev_wr = wr_n;
      next_r.prev_cs = cs_n;
      case (r.state)
         ST_IDLE: begin
            next_r.doe = 1'b0;
            if (style) begin
               // Separate strobes only count while selected
               if (!cs_n && r.prev_rd && !rd_n) begin
                  next_r.addr = addr_s;
                  next_r.dout = rbyte;
                  next_r.doe = 1'b1;
                  next_r.state = ST_READ;
               end else if (!cs_n && r.prev_wr && !wr_n) begin
                  next_r.addr = addr_s;
                  next_r.wlatch = data_s;
                  next_r.state = ST_WRITE;
               end
            end else if (r.prev_cs && !cs_n) begin
               // Read strobe is ignored here; direction is a level
               next_r.addr = addr_s;
               if (wr_n) begin
                  next_r.dout = rbyte;
                  next_r.doe = 1'b1;
                  next_r.state = ST_READ;
               end else begin
                  next_r.wlatch = data_s;
                  next_r.state = ST_WRITE;
               end
            end
         end
         ST_READ: begin
            if (style ? (rd_n || cs_n) : cs_n) begin
               next_r.doe = 1'b0;
               next_r.state = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (style ? (!wr_n && !cs_n) : !cs_n) begin
               // Keep the last byte seen while the strobe is low
               next_r.wlatch = data_s;
            end else begin
               if (r.addr[ADDR_GLOBAL_BIT]) begin
                  next_r.greg[r.addr[ADDR_REG_LSB +: 4]] = r.wlatch;
               end else begin
                  next_r.creg[r.addr[ADDR_CH_LSB +: 3]]
                             [r.addr[ADDR_REG_LSB +: 4]] = r.wlatch;
               end
               next_r.state = ST_IDLE;
            end
         end
         default: begin
            next_r.doe = 1'b0;
            next_r.state = ST_IDLE;
         end
      endcase

      for (int i = 0; i < 8; i++) begin
         fc = r.creg[i][REG_FEATURE];
         ef = r.creg[i][REG_ENH_FEATURE];
         mc = r.creg[i][REG_MODEM_CTL];
         ie = r.creg[i][REG_IRQ_EN];
         // Infrared encoding is a plain inversion; pulse shaping is
         // left to the serial engine
         next_r.sout[i] = mc[MC_IR_BIT] ? ~tx_data[i] : tx_data[i];
         rx_p = r.pin2[P_RX+i];
         if (mc[MC_IR_BIT]) begin
            next_r.rxd[i] = ~(rx_p ^ fc[FC_RX_INV_BIT]);
         end else begin
            next_r.rxd[i] = rx_p;
         end
         full = rx_fill[i] >= fc[FC_THR_LSB +: 4];
         if (fc[FC_HALF_DUPLEX_BIT]) begin
            next_r.rts[i] = ~tx_busy[i];
            next_r.dtr[i] = ~tx_busy[i];
         end else if (ef[EF_AUTO_OUT_BIT] && ie[IE_AUTO_OUT_BIT]) begin
            next_r.rts[i] = full | ~mc[MC_SEND_BIT];
            next_r.dtr[i] = full | ~mc[MC_READY_BIT];
         end else begin
            next_r.rts[i] = ~mc[MC_SEND_BIT];
            next_r.dtr[i] = ~mc[MC_READY_BIT];
         end
         next_r.allow[i] = ~(ef[EF_AUTO_IN_BIT] & ie[IE_AUTO_IN_BIT]) |
                           (~r.pin2[P_CTS+i] & ~r.pin2[P_DSR+i]);
      end
      next_r.irq_oe = |pend;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; pins reset to their idle level
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
         r.state <= ST_IDLE;
         r.pin1 <= PIN_RST;
         r.pin2 <= PIN_RST;
         r.prev_rd <= 1'b1;
         r.prev_wr <= 1'b1;
         r.prev_cs <= 1'b1;
         r.rts <= 8'hff;
         r.dtr <= 8'hff;
         r.rxd <= 8'hff;
         r.sout <= 8'hff;
         r.allow <= 8'hff;
      end else begin
         r <= next_r;
      end
   end

   // Outputs
   assign bus.dev_data_out = r.dout;
   assign bus.dev_data_oe = r.doe;
   assign bus.irq_out_n = 1'b0; // Open drain: only ever pulls low
   assign bus.irq_oe = r.irq_oe;
   assign serial_out_ch = r.sout;
   assign request_send_n = r.rts;
   assign terminal_ready_n = r.dtr;
   assign rx_data = r.rxd;
   assign tx_allow = r.allow;
endmodule

// ### verilog/osp_host.sv
// Host end: runs one bus cycle per command in either bus style
`timescale 1ns/1ps
module osp_host
   import osp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Host bus
   osp_bus_if.host bus,
   // Command port
   input wire logic bus_style,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic busy,
   output logic irq_pending
);
   import osp_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD}
      osp_host_state_e;

   typedef struct packed {
      osp_host_state_e state;
      logic [CNT_W-1:0] cnt;
      logic style;
      logic is_rd;
      logic [7:0] addr;
      logic [7:0] dout;
      logic doe;
      logic rd_n;
      logic wr_n;
      logic cs_n;
      logic [7:0] rdata;
      logic rvalid;
   } osp_host_s;

   osp_host_s r;
   osp_host_s next_r;

   ////////////////////////////////////////////////////////////////////////
   // Setup, strobe and hold phases; address stays put throughout, select too in separate style
   always_comb begin
      next_r = r;
      next_r.rvalid = 1'b0;
      case (r.state)
         H_IDLE: begin
            next_r.style = bus_style;
            if (cmd_wr || cmd_rd) begin
               next_r.is_rd = cmd_rd;
               next_r.addr = cmd_addr;
               next_r.dout = cmd_wdata;
               next_r.doe = ~cmd_rd;
               next_r.rd_n = 1'b1;
               next_r.wr_n = bus_style ? 1'b1 : cmd_rd;
               next_r.cs_n = ~bus_style;
               next_r.cnt = CNT_W'(SETUP_CYC - 1);
               next_r.state = H_SETUP;
            end
         end
         H_SETUP: begin
            next_r.cnt = r.cnt - 1'b1;
            if (r.cnt == '0) begin
               if (!r.style) begin
                  next_r.cs_n = 1'b0;
               end else if (r.is_rd) begin
                  next_r.rd_n = 1'b0;
               end else begin
                  next_r.wr_n = 1'b0;
               end
               next_r.cnt = CNT_W'(STROBE_CYC - 1);
               next_r.state = H_STROBE;
            end
         end
         H_STROBE: begin
            next_r.cnt = r.cnt - 1'b1;
            if (r.cnt == '0) begin
               if (r.is_rd) begin
                  next_r.rdata = bus.host_byte_bus;
                  next_r.rvalid = 1'b1;
               end
               next_r.rd_n = 1'b1;
               if (r.style) begin
                  next_r.wr_n = 1'b1;
               end else begin
                  next_r.cs_n = 1'b1;
               end
               next_r.cnt = CNT_W'(HOLD_CYC - 1);
               next_r.state = H_HOLD;
            end
         end
         H_HOLD: begin
            // Address, data and select held past the strobe's end; single style select is the strobe
            next_r.cnt = r.cnt - 1'b1;
            if (r.cnt == '0) begin
               next_r.cs_n = 1'b1;
               next_r.wr_n = 1'b1;
               next_r.doe = 1'b0;
               next_r.state = H_IDLE;
            end
         end
         default: begin
            next_r.state = H_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; strobes idle high
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
         r.state <= H_IDLE;
         r.style <= 1'b1;
         r.rd_n <= 1'b1;
         r.wr_n <= 1'b1;
         r.cs_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Outputs
   assign bus.host_addr_bus = r.addr;
   assign bus.host_data_out = r.dout;
   assign bus.host_data_oe = r.doe;
   assign bus.read_strobe_n = r.rd_n;
   assign bus.write_strobe_n = r.wr_n;
   assign bus.chip_sel_n = r.cs_n;
   assign bus.bus_style = r.style;
   assign rd_data = r.rdata;
   assign rd_valid = r.rvalid;
   assign busy = r.state != H_IDLE;
   assign irq_pending = ~bus.irq_line_n;
endmodule

// ### test/osp_bus_sva.sv
// Checker for the host bus joining the host end and the device end
`timescale 1ns/1ps
module osp_bus_sva (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Host bus signals
   input wire logic [7:0] host_addr_bus,
   input wire logic host_data_oe,
   input wire logic dev_data_oe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic chip_sel_n,
   input wire logic bus_style,
   input wire logic irq_out_n,
   input wire logic irq_oe
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////
   // Read requests in each style, and the synchronised answer
   sequence sep_rd_s;
      bus_style && !chip_sel_n && $fell(read_strobe_n);
   endsequence
   sequence one_rd_s;
      !bus_style && write_strobe_n && $fell(chip_sel_n);
   endsequence
   // Two sync stages plus the output register
   sequence answer_s;
      ##[2:4] dev_data_oe;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   sep_read_a: assert property (sep_rd_s |-> answer_s)
      else $error("separate read got no data drive");
   one_read_a: assert property (one_rd_s |-> answer_s)
      else $error("single strobe read got no data drive");
   read_release_a: assert property (
      $rose(bus_style ? read_strobe_n : chip_sel_n) |-> ##[1:4] !dev_data_oe)
      else $error("device kept the data bus after the strobe");
   write_quiet_a: assert property (
      !write_strobe_n && !chip_sel_n |-> !dev_data_oe)
      else $error("device drove the bus during a write");
   sep_select_a: assert property (
      bus_style && chip_sel_n |-> !dev_data_oe)
      else $error("device drove the bus while not selected");
   no_clash_a: assert property (!(host_data_oe && dev_data_oe))
      else $error("both ends drove the data bus");
   read_idle_a: assert property (!bus_style |-> read_strobe_n)
      else $error("read strobe low in single strobe style");
   addr_hold_a: assert property (
      !chip_sel_n && $past(chip_sel_n) == 1'h0 |->
      $stable(host_addr_bus) && $stable(bus_style))
      else $error("address or style moved during a select");
   irq_drain_a: assert property (irq_oe |-> !irq_out_n)
      else $error("interrupt output driven high");
endmodule

// ### test/octal_serial_host_bus_port_tb.sv
// Testbench joining the host end and the device end over the host bus
`timescale 1ns/1ps
module octal_serial_host_bus_port_tb;
   import osp_pkg::*;
   typedef struct packed {
      logic s;
      logic [7:0] a;
      logic [7:0] d;
   } osp_row_s;
   logic clk_sys = 1'h0;
   logic reset_n = 1'h0;
   logic style = 1'h1;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] cmd_wdata = 8'h00;
   logic cmd_wr = 1'h0;
   logic cmd_rd = 1'h0;
   logic [7:0] rd_data, rx_data, tx_allow, serial_out_ch, q;
   logic [7:0] request_send_n, terminal_ready_n;
   logic rd_valid, busy, irq_pending;
   logic [7:0] tx_data = 8'hff;
   logic [7:0] tx_busy = 8'h00;
   logic [7:0][3:0] rx_fill = '0;
   logic [7:0] chan_irq = 8'h00;
   logic [7:0] rx_in = 8'hff;
   logic [7:0] cts_n = 8'hff;
   logic [7:0] dsr_n = 8'hff;
   logic [7:0] cd_n = 8'hff;
   logic [7:0] ri_n = 8'hff;
   int error_cnt = 0;
   int n_checks = 0;
   // Rows alias the same low address bits across channels and global space
   osp_row_s rows [6] = '{'{1'h1, 8'h02, 8'h5a}, '{1'h0, 8'h12, 8'ha5},
      '{1'h1, 8'h72, 8'h3c}, '{1'h0, 8'h82, 8'hc3},
      '{1'h1, 8'h8f, 8'h0f}, '{1'h0, 8'h7f, 8'hf0}};
   ////////////////////////////////////////////////////////////////////////
   osp_bus_if bus ();
   osp_bus_if fault_bus ();
   osp_host osp_host_i (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus),
      .bus_style(style), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .rd_data(rd_data),
      .rd_valid(rd_valid), .busy(busy), .irq_pending(irq_pending));
   osp_device osp_device_i (.clk_sys(clk_sys), .reset_n(reset_n),
      .bus(bus), .tx_data(tx_data), .tx_busy(tx_busy), .rx_fill(rx_fill),
      .chan_irq(chan_irq), .rx_data(rx_data), .tx_allow(tx_allow),
      .serial_out_ch(serial_out_ch), .serial_in_ch(rx_in),
      .request_send_n(request_send_n), .clear_send_n(cts_n),
      .terminal_ready_n(terminal_ready_n), .set_ready_n(dsr_n),
      .carrier_detect_n(cd_n), .ring_indicate_n(ri_n));
   // Second device faces a bench driver that breaks the bus rules
   osp_device fault_dev (.clk_sys(clk_sys), .reset_n(reset_n),
      .bus(fault_bus), .tx_data(tx_data), .tx_busy(tx_busy),
      .rx_fill(rx_fill), .chan_irq(8'h00), .rx_data(), .tx_allow(),
      .serial_out_ch(), .serial_in_ch(rx_in), .request_send_n(),
      .clear_send_n(cts_n), .terminal_ready_n(), .set_ready_n(dsr_n),
      .carrier_detect_n(cd_n), .ring_indicate_n(ri_n));
   osp_bus_sva osp_bus_sva_i (.clk_sys(clk_sys), .reset_n(reset_n),
      .host_addr_bus(bus.host_addr_bus), .host_data_oe(bus.host_data_oe),
      .dev_data_oe(bus.dev_data_oe), .read_strobe_n(bus.read_strobe_n),
      .write_strobe_n(bus.write_strobe_n), .chip_sel_n(bus.chip_sel_n),
      .bus_style(bus.bus_style), .irq_out_n(bus.irq_out_n),
      .irq_oe(bus.irq_oe));
   ////////////////////////////////////////////////////////////////////////
   // Free running system clock
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic chk(input string what, input logic [7:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One host command; waits for busy to drop, bounded
   task automatic op(input logic s, w, input logic [7:0] a, d,
         output logic [7:0] r);
      int n;
      logic v;
      v = 1'h0;
      @(posedge clk_sys);
      style <= s;
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= w;
      cmd_rd <= !w;
      @(posedge clk_sys);
      cmd_wr <= 1'h0;
      cmd_rd <= 1'h0;
      #1;
      // A stuck host counts as a mismatch rather than hanging here
      for (n = 0; n < 40 && busy !== 1'h0; n++) begin
         @(posedge clk_sys);
         v |= rd_valid;
      end
      chk("op end", {7'h0, busy}, 8'h00);
      chk("valid", {7'h0, v}, {7'h0, !w});
      r = rd_data;
   endtask
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] r;
      op(1'h0, 1'h1, a, d, r);
   endtask
   // Pins pass two sync stages and a register before they show
   task automatic settle();
      repeat (6) @(posedge clk_sys);
      #1;
   endtask
   // Read strobe on the second bus; reports whether the device answered
   task automatic pulse(input logic s, c, input logic [7:0] exp);
      logic seen;
      seen = 1'h0;
      @(posedge clk_sys);
      fault_bus.bus_style <= s;
      fault_bus.chip_sel_n <= c;
      fault_bus.read_strobe_n <= 1'h0;
      repeat (6) begin
         @(posedge clk_sys);
         seen |= fault_bus.dev_data_oe;
      end
      fault_bus.read_strobe_n <= 1'h1;
      fault_bus.chip_sel_n <= 1'h1;
      repeat (6) @(posedge clk_sys);
      chk("stray read", {7'h0, seen}, exp);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watchdog: the run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      $display("ERROR watchdog expected finish seen hang");
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      fault_bus.host_addr_bus = 8'h80;
      fault_bus.host_data_out = 8'h00;
      fault_bus.host_data_oe = 1'h0;
      fault_bus.read_strobe_n = 1'h1;
      fault_bus.write_strobe_n = 1'h1;
      fault_bus.chip_sel_n = 1'h1;
      fault_bus.bus_style = 1'h1;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'h1;
      settle();
      chk("rts", request_send_n, 8'hff);
      chk("rx", rx_data, 8'hff);
      chk("tx", serial_out_ch, 8'hff);
      chk("allow", tx_allow, 8'hff);
      $display("reset done");
      // Write all rows first so a decode slip overwrites a neighbour
      foreach (rows[i]) op(rows[i].s, 1'h1, rows[i].a, rows[i].d, q);
      foreach (rows[i]) begin
         op(!rows[i].s, 1'h0, rows[i].a, 8'h00, q);
         chk("reg", q, rows[i].d);
      end
      $display("table done");
      // Infrared on channel 0, then receive inversion
      wr(8'h04, 8'h43);
      settle();
      chk("rts", request_send_n, 8'hfe);
      chk("dtr", terminal_ready_n, 8'hfe);
      chk("tx", serial_out_ch, 8'hfe);
      chk("rx", rx_data, 8'hfe);
      wr(8'h08, 8'h10);
      settle();
      chk("rx", rx_data, 8'hff);
      // Channel 1 stays in normal mode, so its bit follows the pin
      @(posedge clk_sys);
      rx_in <= 8'hfd;
      settle();
      chk("rx", rx_data, 8'hfd);
      // Half-duplex direction on channel 1 follows the transmitter
      wr(8'h18, 8'h20);
      @(posedge clk_sys);
      tx_busy <= 8'h02;
      settle();
      chk("rts", request_send_n, 8'hfc);
      chk("dtr", terminal_ready_n, 8'hfc);
      // Auto output flow on channel 2 around a threshold of four
      wr(8'h29, 8'h40);
      wr(8'h21, 8'h40);
      wr(8'h28, 8'h04);
      wr(8'h24, 8'h03);
      @(posedge clk_sys);
      rx_fill[2] <= 4'h4;
      settle();
      chk("rts", request_send_n, 8'hfc);
      @(posedge clk_sys);
      rx_fill[2] <= 4'h3;
      settle();
      chk("dtr", terminal_ready_n, 8'hf8);
      // Auto input flow on channel 3 needs both inputs low
      wr(8'h39, 8'h80);
      wr(8'h31, 8'h80);
      @(posedge clk_sys);
      cts_n <= 8'hf7;
      settle();
      chk("allow", tx_allow, 8'hf7);
      @(posedge clk_sys);
      dsr_n <= 8'hd7;
      cd_n <= 8'hdf;
      settle();
      chk("allow", tx_allow, 8'hff);
      op(1'h1, 1'h0, 8'h56, 8'h00, q);
      chk("status", q, 8'ha0);
      $display("pins done");
      // Channel 0 request stays masked; channel 4 is enabled
      wr(8'h41, 8'h01);
      @(posedge clk_sys);
      chan_irq <= 8'h11;
      settle();
      chk("irq", {7'h0, irq_pending}, 8'h01);
      wr(8'h80, 8'hff);
      op(1'h1, 1'h0, 8'h80, 8'h00, q);
      chk("vector", q, 8'h10);
      @(posedge clk_sys);
      chan_irq <= 8'h00;
      settle();
      chk("irq", {7'h0, irq_pending}, 8'h00);
      $display("irq done");
      pulse(1'h1, 1'h1, 8'h00);
      pulse(1'h0, 1'h1, 8'h00);
      pulse(1'h1, 1'h0, 8'h01);
      $display("faults done");
      wrap_up();
   end
endmodule
